// ### hdl/pgd_consts.svh
`ifndef PGD_CONSTS_SVH
`define PGD_CONSTS_SVH

`define PGD_SR_W 32
`define PGD_VERIFY_BITS 48
`define PGD_RESYNC_BITS 48
`define PGD_RESYNC_ERRS 6
`define PGD_QUASI_RANDOM_MODE_ZEROS 14
`define PGD_CNT_W 6
`define PGD_ERR_CNT_W 32

`define PGD_RB_RX_BITS 2'h0
`define PGD_RB_ERR_CNT 2'h1
`define PGD_RB_GEN_REG 2'h2

`define PGD_SEED 32'hffffffff
`define PGD_TAP_PRBS31 5'h02
`define PGD_LEN_PRBS31 5'h1e
`define PGD_TAP_PRBS15 5'h0d
`define PGD_LEN_PRBS15 5'h0e
`define PGD_TAP_PRBS23 5'h11
`define PGD_LEN_PRBS23 5'h16
`define PGD_TAP_QUASI_RANDOM_MODE 5'h10
`define PGD_LEN_QUASI_RANDOM_MODE 5'h13
`define PGD_TAP_REP 5'h00
`define PGD_LEN_ONE_IN_8 5'h07
`define PGD_IR_ONE_IN_8 32'hffffff01
`define PGD_LEN_ALL_ZERO 5'h00
`define PGD_IR_ALL_ZERO 32'hfffffffe
`define PGD_LEN_ALL_ONE 5'h00

`endif

// ### hdl/pgd_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "pgd_consts.svh"

// Notes on behaviour
// - Pattern in PLCP or frame payload, never cells
// - Generator is 32-bit shift register plus XOR
// - PRBS mode: length and tap pick XOR inputs
// - Repetitive mode recirculates over programmed length
// - Software sets select high, length N-1
// - Repetitive pattern streams continuously, phase unaligned
// - Capture N bits, verify 48, else restart
// - After lock count errors, resync like PRBS
// - Detector locks any repetition, ignores insertion
// - Update with select 00 returns last 32
// - Configurable for standard PRBS and repetitive patterns
// - 2^31-1 uses tap 02, length 1E
// - 1-in-8 uses length 07, byte 01
// - PRBS seed all FF; zeros use FE
// - Separate tx and rx inversion controls
// - QUASI_RANDOM_MODE uses tap 10, length 13, mode bit

module pgd_device
  import pgd_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  pgd_if.device LNK,
  output logic O_SYNC,
  output logic O_BIT_ERR
);

  // One function serves generator and detector so both predict alike
  function automatic logic pgd_fb(
    input logic [31:0] r,
    input logic [4:0] len,
    input logic [4:0] tap,
    input logic ps
  );
    pgd_fb = ps ? r[len] : (r[len] ^ r[tap]);
  endfunction

  function automatic logic pgd_in_payload(
    input logic plcp_en,
    input logic plcp_slot,
    input logic frame_slot,
    input logic cell_slot
  );
    logic sel;
    sel = plcp_en ? plcp_slot : frame_slot;
    pgd_in_payload = sel && !cell_slot;
  endfunction

  logic [31:0] gen_r;
  logic [4:0] zero_run_r;
  logic tx_bit_r;
  logic tx_valid_r;
  logic tx_slot;
  logic tx_new;
  logic tx_pat;

  logic [31:0] det_r;
  logic [31:0] hist_r;
  pgd_det_st_e st_r;
  logic [5:0] cnt_r;
  logic [2:0] win_err_r;
  logic [31:0] err_cnt_r;
  logic [31:0] rb_r;
  logic err_r;
  logic sync_r;
  logic rx_slot;
  logic rx_b;
  logic rx_pred;
  logic rx_miss;
  logic err_now;

  // Transmit side
  assign tx_slot = LNK.tx_strobe && pgd_in_payload(LNK.plcp_enable,
    LNK.tx_plcp_slot, LNK.tx_frame_slot, LNK.tx_cell_slot);

  assign tx_new = pgd_fb(gen_r, LNK.pattern_length, LNK.pattern_tap,
    LNK.pattern_select);

  // QUASI_RANDOM_MODE caps zero runs so a line coder never sees long silence
  always_comb begin
    if (LNK.quasi_random_mode &&
        zero_run_r == 5'(`PGD_QUASI_RANDOM_MODE_ZEROS)) begin
      tx_pat = 1'b1;
    end else begin
      tx_pat = tx_new ^ LNK.tx_invert;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      gen_r <= `PGD_SEED;
    end else if (LNK.insertion_load) begin
      gen_r <= LNK.insertion_bytes;
    end else if (tx_slot) begin
      gen_r <= {gen_r[30:0], tx_new};
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      zero_run_r <= 5'h00;
    end else if (tx_slot) begin
      if (tx_pat) begin
        zero_run_r <= 5'h00;
      end else begin
        zero_run_r <= zero_run_r + 5'h01;
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      tx_bit_r <= 1'b0;
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= LNK.tx_strobe;
      if (LNK.tx_strobe) begin
        tx_bit_r <= tx_slot ? tx_pat : LNK.tx_bit_in;
      end
    end
  end

  assign LNK.tx_bit_out = tx_bit_r;
  assign LNK.tx_out_valid = tx_valid_r;

  // Receive side
  assign rx_slot = LNK.rx_strobe && pgd_in_payload(LNK.plcp_enable,
    LNK.rx_plcp_slot, LNK.rx_frame_slot, LNK.rx_cell_slot);

  assign rx_b = LNK.rx_bit ^ LNK.rx_invert;
  assign rx_pred = pgd_fb(det_r, LNK.pattern_length, LNK.pattern_tap,
    LNK.pattern_select);
  assign rx_miss = rx_b != rx_pred;
  assign err_now = rx_slot && st_r == PGD_ST_SYNC && rx_miss;

  // Hunting loads from the line; once locked it flywheels on prediction
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      det_r <= 32'h00000000;
    end else if (rx_slot) begin
      if (st_r == PGD_ST_SYNC) begin
        det_r <= {det_r[30:0], rx_pred};
      end else begin
        det_r <= {det_r[30:0], rx_b};
      end
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      hist_r <= 32'h00000000;
    end else if (rx_slot) begin
      hist_r <= {hist_r[30:0], LNK.rx_bit};
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      st_r <= PGD_ST_LOAD;
      cnt_r <= 6'h00;
      win_err_r <= 3'h0;
    end else if (rx_slot) begin
      case (st_r)
        PGD_ST_LOAD: begin
          if (cnt_r == {1'b0, LNK.pattern_length}) begin
            st_r <= PGD_ST_VERIFY;
            cnt_r <= 6'h00;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        PGD_ST_VERIFY: begin
          if (rx_miss) begin
            st_r <= PGD_ST_LOAD;
            cnt_r <= 6'h00;
          end else if (cnt_r == 6'(`PGD_VERIFY_BITS - 1)) begin
            st_r <= PGD_ST_SYNC;
            cnt_r <= 6'h00;
            win_err_r <= 3'h0;
          end else begin
            cnt_r <= cnt_r + 6'h01;
          end
        end
        PGD_ST_SYNC: begin
          if (rx_miss &&
              win_err_r == 3'(`PGD_RESYNC_ERRS - 1)) begin
            st_r <= PGD_ST_LOAD;
            cnt_r <= 6'h00;
            win_err_r <= 3'h0;
          end else if (cnt_r == 6'(`PGD_RESYNC_BITS - 1)) begin
            cnt_r <= 6'h00;
            win_err_r <= 3'h0;
          end else begin
            cnt_r <= cnt_r + 6'h01;
            win_err_r <= win_err_r + {2'b00, rx_miss};
          end
        end
        default: begin
          st_r <= PGD_ST_LOAD;
          cnt_r <= 6'h00;
          win_err_r <= 3'h0;
        end
      endcase
    end
  end

  // Counter clears on each update; an error in that same cycle survives
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      err_cnt_r <= 32'h00000000;
    end else if (LNK.update_strobe) begin
      err_cnt_r <= {31'h00000000, err_now};
    end else if (err_now && err_cnt_r != 32'hffffffff) begin
      err_cnt_r <= err_cnt_r + 32'h00000001;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      rb_r <= 32'h00000000;
    end else if (LNK.update_strobe) begin
      case (LNK.detector_readback_select)
        `PGD_RB_RX_BITS: rb_r <= hist_r;
        `PGD_RB_ERR_CNT: rb_r <= err_cnt_r;
        `PGD_RB_GEN_REG: rb_r <= gen_r;
        default: rb_r <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      err_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      err_r <= err_now;
      sync_r <= st_r == PGD_ST_SYNC;
    end
  end

  assign LNK.readback = rb_r;
  assign LNK.det_sync = sync_r;
  assign O_SYNC = sync_r;
  assign O_BIT_ERR = err_r;

endmodule

`default_nettype wire

// ### hdl/pgd_host.sv
`timescale 1ns/100ps
`default_nettype none
`include "pgd_consts.svh"

module pgd_host
  import pgd_pkg::*;
(
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  pgd_if.host LNK,
  input wire pgd_pat_e I_PAT_CODE,
  input wire logic [5:0] I_REP_LEN,
  input wire logic [31:0] I_REP_WORD,
  input wire logic I_APPLY,
  input wire logic I_PLCP_EN,
  input wire logic [1:0] I_READ_SEL,
  input wire logic I_UPDATE,
  input wire logic I_TX_STROBE,
  input wire logic I_TX_PLCP_SLOT,
  input wire logic I_TX_FRAME_SLOT,
  input wire logic I_TX_CELL_SLOT,
  input wire logic I_TX_BIT,
  input wire logic I_RX_STROBE,
  input wire logic I_RX_PLCP_SLOT,
  input wire logic I_RX_FRAME_SLOT,
  input wire logic I_RX_CELL_SLOT,
  input wire logic I_RX_BIT,
  output logic O_TX_BIT,
  output logic O_TX_VALID,
  output logic O_SYNC,
  output logic [31:0] O_READBACK
);

  logic ps_r;
  logic [4:0] len_r;
  logic [4:0] tap_r;
  logic tx_invert_r;
  logic rx_invert_r;
  logic quasi_random_mode_r;
  logic [31:0] ir_r;
  logic load_r;

  // Pattern table; a new code takes effect with a fresh seed load
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      ps_r <= 1'b0;
      len_r <= `PGD_LEN_PRBS31;
      tap_r <= `PGD_TAP_PRBS31;
      tx_invert_r <= 1'b0;
      rx_invert_r <= 1'b0;
      quasi_random_mode_r <= 1'b0;
      ir_r <= `PGD_SEED;
    end else if (I_APPLY) begin
      ps_r <= 1'b0;
      tap_r <= `PGD_TAP_REP;
      tx_invert_r <= 1'b0;
      rx_invert_r <= 1'b0;
      quasi_random_mode_r <= 1'b0;
      ir_r <= `PGD_SEED;
      case (I_PAT_CODE)
        PGD_PAT_PRBS31: begin
          tap_r <= `PGD_TAP_PRBS31;
          len_r <= `PGD_LEN_PRBS31;
        end
        PGD_PAT_PRBS15: begin
          tap_r <= `PGD_TAP_PRBS15;
          len_r <= `PGD_LEN_PRBS15;
          tx_invert_r <= 1'b1;
          rx_invert_r <= 1'b1;
        end
        PGD_PAT_PRBS23: begin
          tap_r <= `PGD_TAP_PRBS23;
          len_r <= `PGD_LEN_PRBS23;
          tx_invert_r <= 1'b1;
          rx_invert_r <= 1'b1;
        end
        PGD_PAT_QUASI_RANDOM_MODE: begin
          tap_r <= `PGD_TAP_QUASI_RANDOM_MODE;
          len_r <= `PGD_LEN_QUASI_RANDOM_MODE;
          quasi_random_mode_r <= 1'b1;
        end
        PGD_PAT_ONE_IN_8: begin
          ps_r <= 1'b1;
          len_r <= `PGD_LEN_ONE_IN_8;
          ir_r <= `PGD_IR_ONE_IN_8;
        end
        PGD_PAT_ALL_ZERO: begin
          ps_r <= 1'b1;
          len_r <= `PGD_LEN_ALL_ZERO;
          ir_r <= `PGD_IR_ALL_ZERO;
        end
        PGD_PAT_ALL_ONE: begin
          ps_r <= 1'b1;
          len_r <= `PGD_LEN_ALL_ONE;
        end
        default: begin
          ps_r <= 1'b1;
          len_r <= 5'(I_REP_LEN - 6'h01);
          ir_r <= I_REP_WORD;
        end
      endcase
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      load_r <= 1'b0;
    end else begin
      load_r <= I_APPLY;
    end
  end

  assign LNK.pattern_select = ps_r;
  assign LNK.pattern_length = len_r;
  assign LNK.pattern_tap = tap_r;
  assign LNK.tx_invert = tx_invert_r;
  assign LNK.rx_invert = rx_invert_r;
  assign LNK.quasi_random_mode = quasi_random_mode_r;
  assign LNK.insertion_bytes = ir_r;
  assign LNK.insertion_load = load_r;
  assign LNK.detector_readback_select = I_READ_SEL;
  assign LNK.update_strobe = I_UPDATE;
  assign LNK.plcp_enable = I_PLCP_EN;
  assign LNK.tx_strobe = I_TX_STROBE;
  assign LNK.tx_plcp_slot = I_TX_PLCP_SLOT;
  assign LNK.tx_frame_slot = I_TX_FRAME_SLOT;
  assign LNK.tx_cell_slot = I_TX_CELL_SLOT;
  assign LNK.tx_bit_in = I_TX_BIT;
  assign LNK.rx_strobe = I_RX_STROBE;
  assign LNK.rx_plcp_slot = I_RX_PLCP_SLOT;
  assign LNK.rx_frame_slot = I_RX_FRAME_SLOT;
  assign LNK.rx_cell_slot = I_RX_CELL_SLOT;
  assign LNK.rx_bit = I_RX_BIT;
  assign O_TX_BIT = LNK.tx_bit_out;
  assign O_TX_VALID = LNK.tx_out_valid;
  assign O_SYNC = LNK.det_sync;
  assign O_READBACK = LNK.readback;

endmodule

`default_nettype wire

// ### hdl/pgd_if.sv
`timescale 1ns/100ps
`default_nettype none

interface pgd_if;
  logic pattern_select;
  logic [4:0] pattern_length;
  logic [4:0] pattern_tap;
  logic tx_invert;
  logic rx_invert;
  logic quasi_random_mode;
  logic [31:0] insertion_bytes;
  logic insertion_load;
  logic [1:0] detector_readback_select;
  logic update_strobe;
  logic plcp_enable;
  logic tx_strobe;
  logic tx_plcp_slot;
  logic tx_frame_slot;
  logic tx_cell_slot;
  logic tx_bit_in;
  logic tx_bit_out;
  logic tx_out_valid;
  logic rx_strobe;
  logic rx_plcp_slot;
  logic rx_frame_slot;
  logic rx_cell_slot;
  logic rx_bit;
  logic det_sync;
  logic [31:0] readback;

  modport device (
    input pattern_select, pattern_length, pattern_tap, tx_invert, rx_invert,
    input quasi_random_mode, insertion_bytes, insertion_load,
    input detector_readback_select, update_strobe, plcp_enable,
    input tx_strobe, tx_plcp_slot, tx_frame_slot, tx_cell_slot, tx_bit_in,
    input rx_strobe, rx_plcp_slot, rx_frame_slot, rx_cell_slot, rx_bit,
    output tx_bit_out, tx_out_valid, det_sync, readback
  );

  modport host (
    output pattern_select, pattern_length, pattern_tap, tx_invert, rx_invert,
    output quasi_random_mode, insertion_bytes, insertion_load,
    output detector_readback_select, update_strobe, plcp_enable,
    output tx_strobe, tx_plcp_slot, tx_frame_slot, tx_cell_slot, tx_bit_in,
    output rx_strobe, rx_plcp_slot, rx_frame_slot, rx_cell_slot, rx_bit,
    input tx_bit_out, tx_out_valid, det_sync, readback
  );
endinterface

`default_nettype wire

// ### hdl/pgd_pkg.sv
package pgd_pkg;

  typedef enum logic [1:0] {
    PGD_ST_LOAD,
    PGD_ST_VERIFY,
    PGD_ST_SYNC
  } pgd_det_st_e;

  typedef enum logic [2:0] {
    PGD_PAT_PRBS31,
    PGD_PAT_PRBS15,
    PGD_PAT_PRBS23,
    PGD_PAT_QUASI_RANDOM_MODE,
    PGD_PAT_ONE_IN_8,
    PGD_PAT_ALL_ZERO,
    PGD_PAT_ALL_ONE,
    PGD_PAT_REP_N
  } pgd_pat_e;

endpackage

// ### sim/pgd_checker.sv
`timescale 1ns/100ps
`default_nettype none

module pgd_checker (
  input wire logic I_CORE_CLK,
  input wire logic I_SRST,
  input wire logic pattern_select,
  input wire logic [4:0] pattern_length,
  input wire logic quasi_random_mode,
  input wire logic insertion_load,
  input wire logic [1:0] detector_readback_select,
  input wire logic update_strobe,
  input wire logic plcp_enable,
  input wire logic tx_strobe,
  input wire logic tx_plcp_slot,
  input wire logic tx_frame_slot,
  input wire logic tx_cell_slot,
  input wire logic tx_bit_in,
  input wire logic tx_bit_out,
  input wire logic tx_out_valid,
  input wire logic rx_strobe,
  input wire logic rx_plcp_slot,
  input wire logic rx_frame_slot,
  input wire logic rx_cell_slot,
  input wire logic rx_bit,
  input wire logic det_sync,
  input wire logic [31:0] readback
);
  default clocking @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);
  logic tx_slot;
  logic rx_slot;
  logic [31:0] hist_r;
  logic [7:0] since_r;
  logic [4:0] zeros_r;
  assign tx_slot = (plcp_enable ? tx_plcp_slot : tx_frame_slot) &&
    !tx_cell_slot;
  assign rx_slot = (plcp_enable ? rx_plcp_slot : rx_frame_slot) &&
    !rx_cell_slot;

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      hist_r <= 32'h0;
    end else if (rx_strobe && rx_slot) begin
      hist_r <= {hist_r[30:0], rx_bit};
    end
  end

  // Counts from the first slot after lock drops, as the hunt does
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      since_r <= 8'h0;
    end else if (det_sync) begin
      since_r <= {7'h0, rx_strobe && rx_slot};
    end else if (rx_strobe && rx_slot && since_r != 8'hff) begin
      since_r <= since_r + 8'h1;
    end
  end

  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST || !quasi_random_mode) begin
      zeros_r <= 5'h0;
    end else if (tx_out_valid) begin
      zeros_r <= tx_bit_out ? 5'h0 : zeros_r + 5'h1;
    end
  end

  sequence s_pass;
    tx_strobe && !tx_slot;
  endsequence
  sequence s_raw_upd;
    update_strobe && detector_readback_select == 2'h0 && !rx_strobe;
  endsequence

  property p_valid;
    !$past(I_SRST) |-> tx_out_valid == $past(tx_strobe);
  endproperty
  property p_pass;
    s_pass |=> tx_bit_out == $past(tx_bit_in);
  endproperty
  property p_hold;
    $changed(tx_bit_out) |-> tx_out_valid;
  endproperty
  property p_rb_raw;
    s_raw_upd |=> readback == hist_r;
  endproperty
  property p_rb_zero;
    update_strobe && detector_readback_select == 2'h3 |=> readback == 32'h0;
  endproperty
  property p_load;
    insertion_load |=> !insertion_load;
  endproperty
  property p_cfg;
    $changed(pattern_length) || $changed(pattern_select) |-> insertion_load;
  endproperty
  property p_lock;
    $rose(det_sync) |-> since_r >= {3'h0, pattern_length} + 8'd49;
  endproperty
  property p_quasi_random_mode;
    quasi_random_mode |-> zeros_r <= 5'd14;
  endproperty

  a_valid: assert property (p_valid)
    else $error("tx valid not one cycle after strobe");
  a_pass: assert property (p_pass)
    else $error("non-payload bit not passed through");
  a_hold: assert property (p_hold)
    else $error("tx bit moved without a strobe");
  a_rb_raw: assert property (p_rb_raw)
    else $error("readback is not the last 32 bits");
  a_rb_zero: assert property (p_rb_zero)
    else $error("unused readback code not zero");
  a_load: assert property (p_load)
    else $error("insertion load longer than one cycle");
  a_cfg: assert property (p_cfg)
    else $error("config moved without a load");
  a_lock: assert property (p_lock)
    else $error("lock came too early");
  a_quasi_random_mode: assert property (p_quasi_random_mode)
    else $error("zero run too long");
endmodule

`default_nettype wire

// ### sim/prbs_pattern_gen_detect_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module prbs_pattern_gen_detect_tb_top
  import pgd_pkg::*;
;
  logic clk = 1'h0;
  logic srst = 1'h1;
  pgd_pat_e code = PGD_PAT_PRBS31;
  logic [31:0] rb, rb_o;
  logic apply = 1'h0, plcp = 1'h0, upd = 1'h0, ts = 1'h0;
  logic tp = 1'h0, tf = 1'h0, tc = 1'h0, tb = 1'h0;
  logic [1:0] sel = 2'h0;
  logic rs = 1'h0, rbit = 1'h0, flip = 1'h0, txo, txv, sync_o;
  logic dev_sync, bit_err;
  logic [2:0] rp = 3'h0, rp_d = 3'h0;
  int errors = 0, check_count = 0;

  // Loopback delays the qualifiers to match the tx output delay
  always @(posedge clk) begin
    rp_d <= {tp, tf, tc};
    rp <= rp_d;
    rs <= txv;
    rbit <= txo ^ flip;
  end

  initial forever #4 clk = ~clk;

  pgd_if lnk ();
  pgd_host i_pgd_host (.I_CORE_CLK(clk), .I_SRST(srst), .LNK(lnk.host),
    .I_PAT_CODE(code), .I_REP_LEN(6'h05), .I_REP_WORD(32'h16),
    .I_APPLY(apply), .I_PLCP_EN(plcp), .I_READ_SEL(sel), .I_UPDATE(upd),
    .I_TX_STROBE(ts), .I_TX_PLCP_SLOT(tp), .I_TX_FRAME_SLOT(tf),
    .I_TX_CELL_SLOT(tc), .I_TX_BIT(tb), .I_RX_STROBE(rs),
    .I_RX_PLCP_SLOT(rp[2]), .I_RX_FRAME_SLOT(rp[1]), .I_RX_CELL_SLOT(rp[0]),
    .I_RX_BIT(rbit), .O_TX_BIT(txo), .O_TX_VALID(txv), .O_SYNC(sync_o),
    .O_READBACK(rb_o));
  pgd_device i_pgd_device (.I_CORE_CLK(clk), .I_SRST(srst),
    .LNK(lnk.device), .O_SYNC(dev_sync), .O_BIT_ERR(bit_err));
  pgd_checker i_pgd_checker (.I_CORE_CLK(clk), .I_SRST(srst),
    .pattern_select(lnk.pattern_select), .pattern_length(lnk.pattern_length),
    .quasi_random_mode(lnk.quasi_random_mode),
    .insertion_load(lnk.insertion_load),
    .detector_readback_select(lnk.detector_readback_select),
    .update_strobe(lnk.update_strobe), .plcp_enable(lnk.plcp_enable),
    .tx_strobe(lnk.tx_strobe), .tx_plcp_slot(lnk.tx_plcp_slot),
    .tx_frame_slot(lnk.tx_frame_slot), .tx_cell_slot(lnk.tx_cell_slot),
    .tx_bit_in(lnk.tx_bit_in), .tx_bit_out(lnk.tx_bit_out),
    .tx_out_valid(lnk.tx_out_valid), .rx_strobe(lnk.rx_strobe),
    .rx_plcp_slot(lnk.rx_plcp_slot), .rx_frame_slot(lnk.rx_frame_slot),
    .rx_cell_slot(lnk.rx_cell_slot), .rx_bit(lnk.rx_bit),
    .det_sync(lnk.det_sync), .readback(lnk.readback));

  task automatic chk(input logic ok, input string m);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  task automatic send(input logic f, p, c, b, e);
    @(posedge clk);
    {ts, tf, tp, tc, tb, flip} <= {1'h1, f, p, c, b, e};
    @(posedge clk);
    ts <= 1'h0;
    #1;
  endtask

  task automatic pay(input logic e);
    send(1'h1, 1'h0, 1'h0, 1'h0, e);
  endtask

  // Idle gap keeps the update clear of any loopback bit still in flight
  task automatic rd(input logic [1:0] s);
    repeat (3) @(posedge clk);
    {upd, sel} <= {1'h1, s};
    @(posedge clk);
    upd <= 1'h0;
    #1;
    rb = rb_o;
  endtask

  task automatic do_reset;
    @(posedge clk);
    srst <= 1'h1;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
  endtask

  task automatic cfg(input pgd_pat_e c);
    @(posedge clk);
    apply <= 1'h1;
    code <= c;
    @(posedge clk);
    apply <= 1'h0;
  endtask

  task automatic t_slots;
    int n;
    logic p;
    n = 0;
    do_reset;
    cfg(PGD_PAT_ONE_IN_8);
    for (int k = 0; k < 48; k++) begin
      p = k >= 24;
      if (plcp !== p) begin
        @(posedge clk);
        plcp <= p;
      end
      if (k % 3 == 0) begin
        send(!p, p, 1'h0, 1'h0, 1'h0);
        chk(txo === (n % 8 == 7), "slot bit");
        n++;
      end else begin
        send(k % 3 == 1 ? p : !p, k % 3 == 1 ? !p : p, k % 3 == 2,
          k % 3 == 1, 1'h0);
        chk(txo === (k % 3 == 1), "pass bit");
      end
    end
    @(posedge clk);
    plcp <= 1'h0;
    $display("t_slots done");
  endtask

  task automatic t_lock;
    do_reset;
    cfg(PGD_PAT_ONE_IN_8);
    for (int k = 1; k <= 58; k++) begin
      pay(1'h0);
      if (k >= 57) begin
        chk(sync_o === (k == 58) && dev_sync === sync_o, "lock");
      end
    end
    rd(2'h0);
    chk(rb === {4{rb[7:0]}} && $countones(rb[7:0]) == 1, "raw");
    rd(2'h1);
    chk(rb === 32'h0, "no errors");
    pay(1'h1);
    pay(1'h0);
    chk(bit_err === 1'h1 && dev_sync === 1'h1, "err pulse");
    repeat (2) pay(1'h0);
    rd(2'h1);
    chk(rb === 32'h1 && sync_o === 1'h1, "one error");
    chk(bit_err === 1'h0, "err pulse gone");
    rd(2'h3);
    chk(rb === 32'h0, "spare code");
    repeat (6) pay(1'h1);
    repeat (2) pay(1'h0);
    chk(sync_o === 1'h0, "resync");
    $display("t_lock done");
  endtask

  task automatic t_codes;
    logic [31:0] g;
    logic [4:0] tap, len;
    logic ps, inv, q, f, x;
    int z;
    for (int i = 0; i < 8; i++) begin
      ps = i > 3;
      inv = i == 1 || i == 2;
      q = i == 3;
      g = i == 4 ? 32'hffffff01 : i == 5 ? 32'hfffffffe :
        i == 7 ? 32'h00000016 : 32'hffffffff;
      case (i)
        0: {tap, len} = {5'h02, 5'h1e};
        1: {tap, len} = {5'h0d, 5'h0e};
        2: {tap, len} = {5'h11, 5'h16};
        3: {tap, len} = {5'h10, 5'h13};
        4: {tap, len} = {5'h00, 5'h07};
        7: {tap, len} = {5'h00, 5'h04};
        default: {tap, len} = {5'h00, 5'h00};
      endcase
      do_reset;
      cfg(pgd_pat_e'(i));
      rd(2'h2);
      chk(rb === g, "seed");
      chk(lnk.pattern_length === len, "len");
      chk(lnk.pattern_select === ps, "select");
      chk(lnk.pattern_tap === tap, "tap");
      chk(lnk.tx_invert === inv && lnk.rx_invert === inv, "inv");
      chk(lnk.quasi_random_mode === q, "quasi_random_mode");
      z = 0;
      for (int k = 0; k < 120; k++) begin
        f = ps ? g[len] : g[len] ^ g[tap];
        g = {g[30:0], f};
        x = (q && z == 14) ? 1'h1 : f ^ inv;
        z = x ? 0 : z + 1;
        pay(1'h0);
        if (k < 40) chk(txo === x, "gen bit");
      end
      chk(q || sync_o === 1'h1, "code lock");
    end
    $display("t_codes done");
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out;
  end

  initial begin
    do_reset;
    t_slots;
    t_lock;
    t_codes;
    close_out;
  end
endmodule

`default_nettype wire
